// file: rtl/mbrfs_bitpack.sv
// Bit packer: gathers single-bit items into one response data byte.
// Assumes the caller clears it before each byte and never clears and
// writes in the same cycle.
module mbrfs_bitpack (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic [2:0] idx_i,
  input wire logic bit_i,
  output logic [7:0] byte_o
);

  mbrfs_pkg::mbrfs_pack_state_t pack_reg;
  mbrfs_pkg::mbrfs_pack_state_t pack_next;

  // A cleared byte keeps every bit that is never written at zero.
  always_comb begin
    pack_next = pack_reg;
    if (clr_i) begin
      pack_next.bits = 8'h00;
    end
    for (int i = 0; i < 8; i++) begin
      if (wr_i && (idx_i == 3'(i))) begin
        pack_next.bits[i] = bit_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pack_reg <= '0;
    end else begin
      pack_reg <= pack_next;
    end
  end

  assign byte_o = pack_reg.bits;

endmodule

// file: rtl/mbrfs_defines.svh
// Constants of the read-function server: function codes, exception codes,
// request field positions and response header positions.
// Assumes one clock domain and byte-wide request and response streams.
`ifndef MBRFS_DEFINES_SVH
`define MBRFS_DEFINES_SVH

// Supported read function codes.
`define MBRFS_FC_COILS 8'h01
`define MBRFS_FC_DISC 8'h02
`define MBRFS_FC_HOLD 8'h03
`define MBRFS_FC_INREG 8'h04

// An exception answer echoes the function code with this bit set.
`define MBRFS_EXC_FLAG 8'h80
`define MBRFS_EXC_NONE 8'h00
`define MBRFS_EXC_FUNC 8'h01
`define MBRFS_EXC_ADDR 8'h02
`define MBRFS_EXC_VALUE 8'h03

// Byte positions inside a read request (header plus five-byte PDU).
`define MBRFS_RQ_TID_HI 4'h0
`define MBRFS_RQ_TID_LO 4'h1
`define MBRFS_RQ_PID_HI 4'h2
`define MBRFS_RQ_PID_LO 4'h3
`define MBRFS_RQ_UNIT 4'h6
`define MBRFS_RQ_FC 4'h7
`define MBRFS_RQ_ADDR_HI 4'h8
`define MBRFS_RQ_ADDR_LO 4'h9
`define MBRFS_RQ_QTY_HI 4'ha
`define MBRFS_RQ_QTY_LO 4'hb
`define MBRFS_RQ_BYTES 4'hc

// Byte positions inside the response header; the last one is the byte
// count of a normal answer or the exception code of an error answer.
`define MBRFS_RS_LEN_HI 4'h4
`define MBRFS_RS_LEN_LO 4'h5
`define MBRFS_RS_UNIT 4'h6
`define MBRFS_RS_FC 4'h7
`define MBRFS_RS_LAST 4'h8

// Unit identifier, function code and byte count (or exception code).
`define MBRFS_PDU_OVERHEAD 16'h0003
`define MBRFS_BIT_LAST 3'h7

`endif

// file: rtl/mbrfs_pkg.sv
// Types shared by the read-function server modules.
// Assumes the constants of mbrfs_defines.svh for the values carried here.
package mbrfs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHECK = 3'b001,
    ST_HDR = 3'b011,
    ST_FILL = 3'b010,
    ST_CAPT = 3'b110,
    ST_EMIT = 3'b111
  } mbrfs_state_t;

  typedef struct packed {
    logic [15:0] tid;
    logic [15:0] pid;
    logic [7:0] unit;
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] qty;
  } mbrfs_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } mbrfs_byte_t;

  typedef struct packed {
    logic req;
    logic [1:0] sel;
    logic [15:0] addr;
  } mbrfs_tbl_t;

  typedef struct packed {
    mbrfs_state_t st;
    mbrfs_req_t req;
    logic [3:0] rx_cnt;
    logic rx_ready;
    logic [7:0] exc;
    logic [7:0] bcnt;
    logic [3:0] hidx;
    logic [15:0] left;
    logic [2:0] bidx;
    logic [15:0] word;
    logic lo_half;
    logic done;
    mbrfs_byte_t tx;
    mbrfs_tbl_t tbl;
  } mbrfs_top_state_t;

  typedef struct packed {
    logic [7:0] bits;
  } mbrfs_pack_state_t;

endpackage

// file: rtl/mbrfs_top.sv
// Read-function server: parses one Modbus/TCP read request, checks it,
// reads the I/O tables item by item and streams the response bytes.
// Assumes a byte stream with framing from the TCP side and I/O tables that
// answer combinationally in the cycle their read strobe is high.
`include "mbrfs_defines.svh"

// Operation
// - Code 0x01 returns a range of coils
// - Coil request: first address, then quantity
// - Coil addresses start at zero
// - One bit per item, 1 ON
// - First coil in bit 0, ascending
// - Coil last byte padded with zeros
// - Byte count gives following data bytes
// - Code 0x02 returns a range of inputs
// - Input request: first address, then quantity
// - Discrete input addresses start at zero
// - First input in bit 0, ascending
// - Input last byte padded with zeros
// - Code 0x03 returns holding register block
// - Code 0x04 returns input register block
// - Register addresses start at zero
// - Registers sent high byte then low byte
// - Exception echoes code with top bit set
// - Bad code, quantity or address gives exception
// - Transaction identifier copied into response
// - Length counts following bytes including unit
module mbrfs_top #(
  parameter int unsigned COIL_NUM = 32'd16,
  parameter int unsigned DISC_NUM = 32'd16,
  parameter int unsigned HOLD_NUM = 32'd16,
  parameter int unsigned INREG_NUM = 32'd16,
  parameter logic [15:0] MAX_BITS = 16'd2000,
  parameter logic [15:0] MAX_REGS = 16'd125
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  output logic rx_ready_o,
  output mbrfs_pkg::mbrfs_byte_t tx_o,
  input wire logic tx_ready_i,
  output mbrfs_pkg::mbrfs_tbl_t tbl_o,
  input wire logic [15:0] tbl_rdata_i,
  output logic done_o
);

  mbrfs_pkg::mbrfs_top_state_t top_reg;
  mbrfs_pkg::mbrfs_top_state_t top_next;

  logic pack_clr;
  logic pack_wr;
  logic [7:0] pack_byte;
  logic is_bit;
  logic tx_free;
  logic [16:0] end_addr;
  logic [16:0] tbl_size;
  logic [15:0] qty_max;
  logic [15:0] len_field;
  logic [7:0] exc_code;
  logic [7:0] byte_cnt;
  logic [7:0] hdr_byte;

  // The packer holds a partly filled byte while the next item is fetched.
  mbrfs_bitpack i_mbrfs_bitpack (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(pack_clr),
    .wr_i(pack_wr),
    .idx_i(top_reg.bidx),
    .bit_i(tbl_rdata_i[0]),
    .byte_o(pack_byte)
  );

  // Table select 0 and 1 are the bit tables, 2 and 3 the word tables.
  assign is_bit = ~top_reg.tbl.sel[1];
  // The output byte register is free when empty or being taken now.
  assign tx_free = ~top_reg.tx.valid | tx_ready_i;
  // Zero-based start plus quantity must not pass the table end.
  assign end_addr = {1'b0, top_reg.req.addr} + {1'b0, top_reg.req.qty};

  // Bit reads may ask for far more items than register reads.
  always_comb begin
    if (top_reg.req.fc <= `MBRFS_FC_DISC) begin
      qty_max = MAX_BITS;
    end else begin
      qty_max = MAX_REGS;
    end
  end

  // An exception answer carries only unit, function code and exception code.
  always_comb begin
    if (top_reg.exc != `MBRFS_EXC_NONE) begin
      len_field = `MBRFS_PDU_OVERHEAD;
    end else begin
      len_field = `MBRFS_PDU_OVERHEAD + {8'h00, top_reg.bcnt};
    end
  end

  // The checks run in a fixed order so that a request reports one cause only.
  always_comb begin
    if ((top_reg.req.fc < `MBRFS_FC_COILS) || (top_reg.req.fc > `MBRFS_FC_INREG)) begin
      exc_code = `MBRFS_EXC_FUNC;
    end else if (top_reg.rx_cnt != `MBRFS_RQ_BYTES) begin
      exc_code = `MBRFS_EXC_VALUE;
    end else if ((top_reg.req.qty == 16'h0000) || (top_reg.req.qty > qty_max)) begin
      exc_code = `MBRFS_EXC_VALUE;
    end else if (end_addr > tbl_size) begin
      exc_code = `MBRFS_EXC_ADDR;
    end else begin
      exc_code = `MBRFS_EXC_NONE;
    end
  end

  // Bit reads round up to whole bytes; register reads take two bytes each.
  always_comb begin
    if (top_reg.req.fc <= `MBRFS_FC_DISC) begin
      byte_cnt = 8'((top_reg.req.qty + 16'h0007) >> 3);
    end else begin
      byte_cnt = {top_reg.req.qty[6:0], 1'b0};
    end
  end

  // The last header index carries the byte count, or the exception code instead.
  always_comb begin
    case (top_reg.hidx)
      `MBRFS_RQ_TID_HI: hdr_byte = top_reg.req.tid[15:8];
      `MBRFS_RQ_TID_LO: hdr_byte = top_reg.req.tid[7:0];
      `MBRFS_RQ_PID_HI: hdr_byte = top_reg.req.pid[15:8];
      `MBRFS_RQ_PID_LO: hdr_byte = top_reg.req.pid[7:0];
      `MBRFS_RS_LEN_HI: hdr_byte = len_field[15:8];
      `MBRFS_RS_LEN_LO: hdr_byte = len_field[7:0];
      `MBRFS_RS_UNIT: hdr_byte = top_reg.req.unit;
      `MBRFS_RS_FC: begin
        if (top_reg.exc != `MBRFS_EXC_NONE) begin
          hdr_byte = top_reg.req.fc | `MBRFS_EXC_FLAG;
        end else begin
          hdr_byte = top_reg.req.fc;
        end
      end
      default: begin
        if (top_reg.exc != `MBRFS_EXC_NONE) begin
          hdr_byte = top_reg.exc;
        end else begin
          hdr_byte = top_reg.bcnt;
        end
      end
    endcase
  end

  always_comb begin
    case (top_reg.req.fc)
      `MBRFS_FC_COILS: tbl_size = 17'(COIL_NUM);
      `MBRFS_FC_DISC: tbl_size = 17'(DISC_NUM);
      `MBRFS_FC_HOLD: tbl_size = 17'(HOLD_NUM);
      default: tbl_size = 17'(INREG_NUM);
    endcase
  end

  // A request is parsed, checked and answered in one pass; the next one waits for the last answer byte.
  always_comb begin
    top_next = top_reg;
    top_next.tbl.req = 1'b0;
    top_next.done = top_reg.tx.valid & tx_ready_i & top_reg.tx.last;
    pack_clr = 1'b0;
    pack_wr = 1'b0;
    if (top_reg.tx.valid && tx_ready_i) begin
      top_next.tx.valid = 1'b0;
      top_next.tx.last = 1'b0;
    end
    case (top_reg.st)
      mbrfs_pkg::ST_IDLE: begin
        if (rx_valid_i && top_reg.rx_ready) begin
          // Fields are taken in stream order: address first, then quantity.
          case (top_reg.rx_cnt)
            `MBRFS_RQ_TID_HI: top_next.req.tid[15:8] = rx_data_i;
            `MBRFS_RQ_TID_LO: top_next.req.tid[7:0] = rx_data_i;
            `MBRFS_RQ_PID_HI: top_next.req.pid[15:8] = rx_data_i;
            `MBRFS_RQ_PID_LO: top_next.req.pid[7:0] = rx_data_i;
            `MBRFS_RQ_UNIT: top_next.req.unit = rx_data_i;
            `MBRFS_RQ_FC: top_next.req.fc = rx_data_i;
            `MBRFS_RQ_ADDR_HI: top_next.req.addr[15:8] = rx_data_i;
            `MBRFS_RQ_ADDR_LO: top_next.req.addr[7:0] = rx_data_i;
            `MBRFS_RQ_QTY_HI: top_next.req.qty[15:8] = rx_data_i;
            `MBRFS_RQ_QTY_LO: top_next.req.qty[7:0] = rx_data_i;
            default: top_next.req.fc = top_reg.req.fc;
          endcase
          // The counter saturates so that an over-long frame is detectable.
          if (top_reg.rx_cnt < `MBRFS_RQ_BYTES) begin
            top_next.rx_cnt = top_reg.rx_cnt + 4'h1;
          end else begin
            top_next.rx_cnt = 4'hf;
          end
          if (rx_last_i) begin
            top_next.rx_ready = 1'b0;
            top_next.st = mbrfs_pkg::ST_CHECK;
          end
        end
      end
      mbrfs_pkg::ST_CHECK: begin
        top_next.exc = exc_code;
        top_next.bcnt = byte_cnt;
        // Function code selects the table: coils, inputs, holding, input regs.
        top_next.tbl.sel = 2'(top_reg.req.fc - `MBRFS_FC_COILS);
        top_next.tbl.addr = top_reg.req.addr;
        top_next.left = top_reg.req.qty;
        top_next.bidx = 3'h0;
        top_next.lo_half = 1'b0;
        top_next.hidx = 4'h0;
        pack_clr = 1'b1;
        top_next.st = mbrfs_pkg::ST_HDR;
      end
      mbrfs_pkg::ST_HDR: begin
        // Header bytes leave one per cycle whenever the output register is free.
        if (tx_free) begin
          top_next.tx.valid = 1'b1;
          top_next.tx.last = 1'b0;
          top_next.tx.data = hdr_byte;
          if (top_reg.hidx == `MBRFS_RS_LAST) begin
            if (top_reg.exc != `MBRFS_EXC_NONE) begin
              top_next.tx.last = 1'b1;
              top_next.rx_cnt = 4'h0;
              top_next.rx_ready = 1'b1;
              top_next.st = mbrfs_pkg::ST_IDLE;
            end else begin
              top_next.st = mbrfs_pkg::ST_FILL;
            end
          end else begin
            top_next.hidx = top_reg.hidx + 4'h1;
          end
        end
      end
      mbrfs_pkg::ST_FILL: begin
        // The strobe is registered, so the table sees a stable address for a full cycle.
        top_next.tbl.req = 1'b1;
        top_next.st = mbrfs_pkg::ST_CAPT;
      end
      mbrfs_pkg::ST_CAPT: begin
        // The table answers for the strobed address in this cycle.
        top_next.tbl.addr = top_reg.tbl.addr + 16'h0001;
        top_next.left = top_reg.left - 16'h0001;
        if (is_bit) begin
          pack_wr = 1'b1;
          top_next.bidx = top_reg.bidx + 3'h1;
          if ((top_reg.bidx == `MBRFS_BIT_LAST) || (top_reg.left == 16'h0001)) begin
            top_next.st = mbrfs_pkg::ST_EMIT;
          end else begin
            top_next.st = mbrfs_pkg::ST_FILL;
          end
        end else begin
          top_next.word = tbl_rdata_i;
          top_next.st = mbrfs_pkg::ST_EMIT;
        end
      end
      mbrfs_pkg::ST_EMIT: begin
        // A bit byte leaves when full or after the last item; a register leaves in two halves.
        if (tx_free) begin
          top_next.tx.valid = 1'b1;
          top_next.tx.last = 1'b0;
          if (is_bit) begin
            top_next.tx.data = pack_byte;
            pack_clr = 1'b1;
            top_next.bidx = 3'h0;
          end else if (!top_reg.lo_half) begin
            top_next.tx.data = top_reg.word[15:8];
            top_next.lo_half = 1'b1;
          end else begin
            top_next.tx.data = top_reg.word[7:0];
            top_next.lo_half = 1'b0;
          end
          if (is_bit || top_reg.lo_half) begin
            if (top_reg.left == 16'h0000) begin
              top_next.tx.last = 1'b1;
              top_next.rx_cnt = 4'h0;
              top_next.rx_ready = 1'b1;
              top_next.st = mbrfs_pkg::ST_IDLE;
            end else begin
              top_next.st = mbrfs_pkg::ST_FILL;
            end
          end
        end
      end
      default: begin
        // An unused state code returns to idle instead of locking the server up.
        top_next.rx_cnt = 4'h0;
        top_next.rx_ready = 1'b1;
        top_next.st = mbrfs_pkg::ST_IDLE;
      end
    endcase
  end

  // Reset leaves the server idle and ready for a request.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      top_reg <= '0;
      top_reg.rx_ready <= 1'b1;
    end else begin
      top_reg <= top_next;
    end
  end

  assign rx_ready_o = top_reg.rx_ready;
  assign tx_o = top_reg.tx;
  assign tbl_o = top_reg.tbl;
  assign done_o = top_reg.done;

endmodule

// file: test/mbrfs_client.sv
// Network client model: sends one request frame and collects the answer.
// Assumes the server's byte handshake; drives on the falling edge.
module mbrfs_client (
  input wire logic core_clk_i,
  input wire logic rx_ready_i,
  input wire mbrfs_pkg::mbrfs_byte_t tx_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_last_o,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stall = 1'b0;
  logic [1:0] ph = 2'h0;
  logic [7:0] resp[$];
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_last_o = 1'b0;
    tx_ready_o = 1'b1;
  end
  // A slow sink takes one byte in four, so held bytes are exercised.
  always @(negedge core_clk_i) begin
    ph <= ph + 2'h1;
    tx_ready_o <= !stall || ph == 2'h0;
  end
  always @(posedge core_clk_i) begin
    if (tx_i.valid && tx_ready_o) resp.push_back(tx_i.data);
  end
  task automatic send(input logic [7:0] f[12]);
    for (int i = 0; i < 12; i++) begin
      @(negedge core_clk_i);
      rx_valid_o = 1'b1;
      rx_data_o = f[i];
      rx_last_o = (i == 11);
      while (!rx_ready_i) @(negedge core_clk_i);
    end
    @(negedge core_clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o;
    rx_last_o = 1'b0;
  endtask
endmodule

// file: test/mbrfs_sva.sv
// Port assertions for the read-function server.
// Assumes it is bound to mbrfs_top with one clock and an active-low reset.
module mbrfs_sva (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  input wire logic rx_ready_o,
  input wire mbrfs_pkg::mbrfs_byte_t tx_o,
  input wire logic tx_ready_i,
  input wire mbrfs_pkg::mbrfs_tbl_t tbl_o,
  input wire logic [15:0] tbl_rdata_i,
  input wire logic done_o
);
  logic [95:0] rq_reg;
  logic [8:0] tcnt_reg;
  logic [7:0] fco_reg, len_reg, bc_reg;
  logic first_reg;
  logic [15:0] laddr_reg;
  wire logic rtk = rx_valid_i & rx_ready_o;
  wire logic ttk = tx_o.valid & tx_ready_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // The request is kept as a shift register; its fields sit at fixed offsets once all 12 bytes are in.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rq_reg <= '0;
      tcnt_reg <= '0;
      fco_reg <= '0;
      len_reg <= '0;
      bc_reg <= '0;
      first_reg <= 1'b0;
      laddr_reg <= '0;
    end else begin
      if (rtk) rq_reg <= {rq_reg[87:0], rx_data_i};
      if (rtk && rx_last_i) first_reg <= 1'b1;
      else if (tbl_o.req) first_reg <= 1'b0;
      if (tbl_o.req) laddr_reg <= tbl_o.addr;
      if (ttk) tcnt_reg <= tx_o.last ? 9'h000 : tcnt_reg + 9'h001;
      if (ttk && tcnt_reg == 9'h005) len_reg <= tx_o.data;
      if (ttk && tcnt_reg == 9'h007) fco_reg <= tx_o.data;
      if (ttk && tcnt_reg == 9'h008) bc_reg <= tx_o.data;
    end
  end
  AST_TID_HI: assert property (ttk && tcnt_reg == 9'h000 |-> tx_o.data == rq_reg[95:88])
    else $error("transaction id differs");
  AST_FC: assert property (ttk && tcnt_reg == 9'h007 |-> tx_o.data[6:0] == rq_reg[38:32])
    else $error("function code not echoed");
  AST_LEN: assert property (ttk && tcnt_reg == 9'h008 |->
    len_reg == (fco_reg[7] ? 8'h03 : tx_o.data + 8'h03))
    else $error("length field wrong");
  AST_BCNT: assert property (ttk && tcnt_reg == 9'h008 && !fco_reg[7] |->
    tx_o.data == (rq_reg[39:32] > 8'h02 ? {rq_reg[6:0], 1'b0} : 8'((rq_reg[15:0] + 16'h0007) >> 3)))
    else $error("byte count wrong");
  AST_LAST: assert property (tx_o.valid && tx_o.last |->
    tcnt_reg == (fco_reg[7] ? 9'h008 : 9'h008 + {1'b0, bc_reg}))
    else $error("last byte misplaced");
  AST_DONE: assert property (ttk && tx_o.last |=> done_o)
    else $error("completion pulse missing");
  AST_RX_STOP: assert property (rtk && rx_last_i |=> !rx_ready_o)
    else $error("request bytes still accepted after the last one");
  AST_REQ_PULSE: assert property (tbl_o.req |=> !tbl_o.req)
    else $error("table strobe too long");
  AST_ADDR_FIRST: assert property (tbl_o.req && first_reg |-> tbl_o.addr == rq_reg[31:16])
    else $error("first table address wrong");
  AST_ADDR_NEXT: assert property (tbl_o.req && !first_reg |-> tbl_o.addr == laddr_reg + 16'h0001)
    else $error("table address not ascending");
  AST_SEL: assert property (tbl_o.req |-> tbl_o.sel == rq_reg[33:32] - 2'h1)
    else $error("wrong table selected");
endmodule

bind mbrfs_top mbrfs_sva i_mbrfs_sva (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .rx_valid_i(rx_valid_i),
  .rx_data_i(rx_data_i), .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o), .tx_o(tx_o), .tx_ready_i(tx_ready_i),
  .tbl_o(tbl_o), .tbl_rdata_i(tbl_rdata_i), .done_o(done_o));

// file: test/tb_modbus_read_function_server.sv
// Self-checking bench for the read-function server.
// Assumes the client model on the network side; tables are modelled here.
module tb_modbus_read_function_server;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  int n_fail = 0;
  int check_count = 0;
  logic rx_valid, rx_last, rx_ready, tx_ready, done;
  logic [7:0] rx_data;
  logic [15:0] rdata;
  mbrfs_pkg::mbrfs_byte_t tx;
  mbrfs_pkg::mbrfs_tbl_t tbl;
  mbrfs_top i_mbrfs_top (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_last_i(rx_last), .rx_ready_o(rx_ready), .tx_o(tx), .tx_ready_i(tx_ready), .tbl_o(tbl),
    .tbl_rdata_i(rdata), .done_o(done));
  mbrfs_client i_mbrfs_client (.core_clk_i(core_clk_i), .rx_ready_i(rx_ready), .tx_i(tx), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_last_o(rx_last), .tx_ready_o(tx_ready));
  function automatic logic [15:0] item(input logic [1:0] s, input logic [15:0] a);
    return s[1] ? {s, a[13:0]} ^ 16'h5a00 : {15'h0000, a[0] ^ a[2] ^ s[0]};
  endfunction
  assign rdata = item(tbl.sel, tbl.addr);
  initial forever #10 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic run(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] q, input logic [7:0] exc);
    logic [7:0] f[12];
    logic [7:0] e[$];
    logic [7:0] bc, b;
    logic [15:0] w;
    int k;
    f = '{fc, ~fc, 8'h00, 8'h00, 8'h00, 8'h06, 8'h01, fc, a[15:8], a[7:0], q[15:8], q[7:0]};
    i_mbrfs_client.resp.delete();
    i_mbrfs_client.send(f);
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(negedge core_clk_i);
      k++;
    end
    if (k == 3000) n_fail++;
    bc = (exc != 8'h00) ? exc : (fc > 8'h02 ? {q[6:0], 1'b0} : 8'((q + 16'h0007) >> 3));
    e = '{fc, ~fc, 8'h00, 8'h00, 8'h00, (exc != 8'h00) ? 8'h03 : bc + 8'h03, 8'h01, fc | exc[7:0] & 8'h00, bc};
    if (exc != 8'h00) e[7] = fc | 8'h80;
    for (int i = 0; exc == 8'h00 && i < bc; i++) begin
      w = item(2'(fc - 8'h01), a + 16'(i / 2));
      b = i[0] ? w[7:0] : w[15:8];
      for (int j = 0; fc < 8'h03 && j < 8; j++) begin
        w = item(2'(fc - 8'h01), a + 16'(i * 8 + j));
        b[j] = (i * 8 + j < q) ? w[0] : 1'b0;
      end
      e.push_back(b);
    end
    chk(8'(i_mbrfs_client.resp.size()), 8'(e.size()));
    for (int i = 0; i < e.size() && i < i_mbrfs_client.resp.size(); i++) begin
      chk(i_mbrfs_client.resp[i], e[i]);
    end
  endtask
  task automatic t_coils;
    run(8'h01, 16'h0003, 16'h000a, 8'h00);
  endtask
  task automatic t_disc;
    i_mbrfs_client.stall = 1'b1;
    run(8'h02, 16'h0000, 16'h000d, 8'h00);
    i_mbrfs_client.stall = 1'b0;
  endtask
  task automatic t_regs;
    run(8'h03, 16'h0000, 16'h0002, 8'h00);
    run(8'h04, 16'h000e, 16'h0002, 8'h00);
  endtask
  task automatic t_exc;
    run(8'h06, 16'h0000, 16'h0001, 8'h01);
    run(8'h03, 16'h0000, 16'h0000, 8'h03);
    run(8'h04, 16'h0000, 16'h007e, 8'h03);
    run(8'h01, 16'h000a, 16'h0007, 8'h02);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (16) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    t_coils();
    t_disc();
    t_regs();
    t_exc();
    final_report();
  end
endmodule
